// File: hw/dpx_engine.sv
// Purpose: telegram engine for parameter extensions and acyclic SAPs
// Assumes: telegram fields arrive decoded, one telegram at a time
// Notes: only buffer headers and the entry done flag are written; payload moves elsewhere
// Behaviour
// - Fail-safe required but unsupported sets fault, only while MODE_EXT_USE is also set in mode 0
// - Host enables redundancy commands in mode 0
// - Extended parameters only in wait-for-configuration
// - Extended parameters raise their own interrupt
// - Host enables SAP 53 in mode 0
// - Shared aux buffer; no special buffer mode
// - SAP list of 7-byte entries, FFH ends
// - Acyclic service only when parameter enables it
// - Entry layout: flag, SAP, filters, pointers
// - Source station and SAP mismatch answers RS
// - Service byte 00 allows every service
// - Buffer header: control, capacity, length, code
// - Store request, else RR, then request interrupt
// - Polls raise nothing, answered SC until reply
// - Send reply, clear bits, flag, interrupt
// - Host clears interrupts and handshake bits
// - At most 29 broadcast links
// - Function code 7 published to 127 or ignored
// - Host builds link tables, needs watchdog
// - Link block: type 3/7, slot 0, version 1
`timescale 1ns/1ns
module dpx_engine #(
  parameter int RAM_DEPTH = 2048
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Host side
  dpx_if.engine hif,
  // Telegram request
  input wire logic tg_valid,
  input wire dpx_pkg::dpx_tg_t tg_kind,
  input wire logic [7:0] tg_sap,
  input wire logic [7:0] tg_src_station,
  input wire logic [7:0] tg_src_sap,
  input wire logic [7:0] tg_service,
  input wire logic [7:0] tg_fc,
  input wire logic [7:0] tg_len,
  input wire logic [7:0] tg_status1,
  input wire logic [7:0] tg_status3,
  input wire logic [7:0] tg_blk_type,
  input wire logic [7:0] tg_blk_slot,
  input wire logic [7:0] tg_blk_rsvd,
  input wire logic [7:0] tg_blk_ver,
  output logic tg_ready,
  // Answer
  output logic ans_valid,
  output dpx_pkg::dpx_ans_t ans_code,
  output logic [7:0] ans_dest,
  output logic [10:0] ans_buf_addr
);
  import dpx_pkg::*;

  typedef enum {
    S_IDLE, S_BASE, S_ENTRY, S_SA, S_SSAP, S_SVC, S_IPTR, S_ICTL,
    S_ILEN, S_IFC, S_ICLOSE, S_RPTR, S_RCTL, S_RSENT
  } dpx_walk_t;

  logic [7:0] mem [RAM_DEPTH];
  dpx_walk_t st_reg;
  dpx_dp_t dp_reg;
  logic [10:0] addr_reg, entry_reg, buf_reg;
  logic idx_reg, poll_reg, acyc_en_reg, publish_reg, fault_reg;
  logic [7:0] sap_reg, sa_reg, ssap_reg, svc_reg, fc_reg, len_reg;
  logic [7:0] rdata;
  logic eng_we;
  logic [7:0] eng_wdata;

  function automatic logic [10:0] seg_addr(input logic [7:0] ptr);
    seg_addr = {ptr, 3'b000};
  endfunction

  // Structured block header check, including link tables
  function automatic logic blk_bad(input logic [7:0] len,
    input logic [7:0] typ, input logic [7:0] slot,
    input logic [7:0] rsvd, input logic [7:0] ver);
    logic link;
    link = (typ == LINK_TYPE_A) || (typ == LINK_TYPE_B);
    blk_bad = (len < BLK_HDR_LEN) || (len > BLK_MAX_LEN) ||
      (link && ((slot != 8'h00) || (rsvd != 8'h00) ||
      (ver != LINK_VERSION) || (len > LINK_MAX_LEN)));
  endfunction

  assign rdata = mem[addr_reg];
  assign hif.ram_rdata = mem[hif.ram_addr];
  assign hif.dp_state = dp_reg;
  assign hif.prm_fault = fault_reg;

  // ----------------------------------------------------------------
  // Shared RAM, engine write wins a same-cycle collision
  // ----------------------------------------------------------------
  always_ff @(posedge pclk)
  begin
    if (eng_we)
      mem[addr_reg] <= eng_wdata;
    else if (hif.ram_we)
      mem[hif.ram_addr] <= hif.ram_wdata;
  end

  always_comb
  begin
    eng_we = 1'b0;
    eng_wdata = rdata;
    case (st_reg)
      S_ICTL:
      begin
        eng_we = !rdata[CTL_HOST] && !rdata[CTL_ENG];
        eng_wdata = 8'h00;
        eng_wdata[CTL_ENG] = 1'b1;
      end
      S_ILEN:
      begin
        eng_we = 1'b1;
        eng_wdata = len_reg;
      end
      S_IFC:
      begin
        eng_we = 1'b1;
        eng_wdata = fc_reg;
      end
      S_ICLOSE:
      begin
        eng_we = 1'b1;
        eng_wdata = 8'h00;
        eng_wdata[CTL_HOST] = 1'b1;
        eng_wdata[CTL_PEND] = 1'b1;
      end
      S_RCTL:
      begin
        eng_we = rdata[CTL_RESP];
        eng_wdata[CTL_RESP] = 1'b0;
        eng_wdata[CTL_HOST] = 1'b0;
      end
      S_RSENT:
      begin
        eng_we = 1'b1;
        eng_wdata[REPLY_DONE_BIT] = 1'b1;
      end
      default:
      begin
        eng_we = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Slave state and parameter capture
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dp_reg <= DP_OFFLINE;
      acyc_en_reg <= 1'b0;
      publish_reg <= 1'b0;
      fault_reg <= 1'b0;
    end
    else if (!hif.mode0[MODE_ONLINE])
      dp_reg <= DP_OFFLINE;
    else if (dp_reg == DP_OFFLINE)
      dp_reg <= DP_WAIT_PRM;
    else if (tg_valid && tg_ready)
    begin
      if (tg_kind == TG_PRM)
      begin
        dp_reg <= DP_WAIT_CFG;
        acyc_en_reg <= tg_status1[ST1_ACYC];
        publish_reg <= tg_status1[ST1_PUBLISH];
        fault_reg <= (hif.mode0[MODE_EXT_USE] &&
          hif.mode0[MODE_FAILSAFE] && !tg_status1[ST1_FAILSAFE]) ||
          (tg_status3[ST3_PRMCMD] && !hif.mode0[MODE_REDUND]) ||
          (tg_status3[ST3_STRUCT] && blk_bad(tg_len, tg_blk_type,
          tg_blk_slot, tg_blk_rsvd, tg_blk_ver));
      end
      // extended blocks checked in wait state
      else if (tg_kind == TG_EXT_PRM && dp_reg == DP_WAIT_CFG &&
        hif.mode0[MODE_EXT_PRM])
        fault_reg <= fault_reg || blk_bad(tg_len, tg_blk_type,
          tg_blk_slot, tg_blk_rsvd, tg_blk_ver);
      else if (tg_kind == TG_CHK_CFG && dp_reg == DP_WAIT_CFG)
        dp_reg <= DP_DATA_EX;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hif.link_overflow <= 1'b0;
    else
      hif.link_overflow <= hif.link_count > MAX_LINKS;
  end

  // ----------------------------------------------------------------
  // Telegram handling and SAP list walk
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= S_IDLE;
      addr_reg <= 11'h000;
      entry_reg <= 11'h000;
      buf_reg <= 11'h000;
      idx_reg <= 1'b0;
      poll_reg <= 1'b0;
      sap_reg <= 8'h00;
      sa_reg <= 8'h00;
      ssap_reg <= 8'h00;
      svc_reg <= 8'h00;
      fc_reg <= 8'h00;
      len_reg <= 8'h00;
      tg_ready <= 1'b0;
      ans_valid <= 1'b0;
      ans_code <= ANS_SC;
      ans_dest <= 8'h00;
      ans_buf_addr <= 11'h000;
      hif.prm_irq <= 1'b0;
      hif.ext_prm_irq <= 1'b0;
      hif.request_irq <= 1'b0;
      hif.reply_irq <= 1'b0;
    end
    else
    begin
      ans_valid <= 1'b0;
      hif.prm_irq <= 1'b0;
      hif.ext_prm_irq <= 1'b0;
      hif.request_irq <= 1'b0;
      hif.reply_irq <= 1'b0;
      case (st_reg)
        S_IDLE:
        begin
          tg_ready <= dp_reg != DP_OFFLINE;
          if (tg_valid && tg_ready)
          begin
            tg_ready <= 1'b0;
            ans_valid <= 1'b1;
            ans_code <= ANS_SC;
            ans_dest <= tg_src_station;
            sap_reg <= tg_sap;
            sa_reg <= tg_src_station;
            ssap_reg <= tg_src_sap;
            svc_reg <= tg_service;
            fc_reg <= tg_fc;
            len_reg <= tg_len;
            poll_reg <= tg_kind == TG_ACYC_POLL;
            idx_reg <= 1'b0;
            case (tg_kind)
              TG_PRM:
                hif.prm_irq <= 1'b1;
              TG_EXT_PRM:
                if (dp_reg == DP_WAIT_CFG && hif.mode0[MODE_EXT_PRM])
                  hif.ext_prm_irq <= 1'b1;
                else
                  ans_code <= ANS_RS;
              TG_DX:
                if (tg_fc == FC_PUBLISH)
                begin
                  ans_valid <= publish_reg;
                  ans_code <= ANS_PUBLISH;
                  ans_dest <= DEST_BROADCAST;
                end
                else
                  ans_code <= ANS_DATA;
              TG_ACYC_REQ, TG_ACYC_POLL:
                if (!acyc_en_reg)
                  ans_code <= ANS_RS;
                else
                begin
                  ans_valid <= 1'b0;
                  addr_reg <= SAP_LIST_PTR_ADDR;
                  st_reg <= S_BASE;
                end
              default:
                ans_code <= ANS_SC;
            endcase
          end
        end
        S_BASE:
        begin
          addr_reg <= seg_addr(rdata);
          st_reg <= S_ENTRY;
        end
        S_ENTRY:
          if (rdata == LIST_END)
          begin
            ans_valid <= 1'b1;
            ans_code <= ANS_RS;
            st_reg <= S_IDLE;
          end
          else if ({1'b0, rdata[6:0]} == sap_reg)
          begin
            entry_reg <= addr_reg;
            addr_reg <= addr_reg + OFS_SRC_STATION;
            st_reg <= S_SA;
          end
          else
            addr_reg <= addr_reg + ENTRY_SIZE;
        S_SA, S_SSAP:
          if (rdata != ((st_reg == S_SA) ? sa_reg : ssap_reg))
          begin
            ans_valid <= 1'b1;
            ans_code <= ANS_RS;
            st_reg <= S_IDLE;
          end
          else
          begin
            addr_reg <= addr_reg + OFS_SRC_STATION;
            st_reg <= (st_reg == S_SA) ? S_SSAP : S_SVC;
          end
        S_SVC:
          if (rdata != SERVICE_ANY && rdata != svc_reg)
          begin
            ans_valid <= 1'b1;
            ans_code <= ANS_RS;
            st_reg <= S_IDLE;
          end
          else
          begin
            addr_reg <= entry_reg + (poll_reg ? OFS_REPLY_PTR :
              OFS_REQ_PTR0);
            st_reg <= poll_reg ? S_RPTR : S_IPTR;
          end
        S_IPTR:
        begin
          buf_reg <= seg_addr(rdata);
          addr_reg <= seg_addr(rdata);
          st_reg <= S_ICTL;
        end
        // first free buffer, pointer 0 first
        S_ICTL:
          if (!rdata[CTL_HOST] && !rdata[CTL_ENG])
          begin
            addr_reg <= buf_reg + OFS_BUF_LEN;
            st_reg <= S_ILEN;
          end
          else if (!idx_reg)
          begin
            idx_reg <= 1'b1;
            addr_reg <= entry_reg + OFS_REQ_PTR1;
            st_reg <= S_IPTR;
          end
          else
          begin
            ans_valid <= 1'b1;
            ans_code <= ANS_RR;
            st_reg <= S_IDLE;
          end
        S_ILEN:
        begin
          addr_reg <= buf_reg + OFS_BUF_FC;
          st_reg <= S_IFC;
        end
        S_IFC:
        begin
          addr_reg <= buf_reg;
          st_reg <= S_ICLOSE;
        end
        S_ICLOSE:
        begin
          hif.request_irq <= 1'b1;
          ans_valid <= 1'b1;
          ans_code <= ANS_SC;
          ans_buf_addr <= buf_reg;
          st_reg <= S_IDLE;
        end
        S_RPTR:
        begin
          buf_reg <= seg_addr(rdata);
          addr_reg <= seg_addr(rdata);
          st_reg <= S_RCTL;
        end
        // plain SC until a reply is present
        S_RCTL:
        begin
          ans_valid <= 1'b1;
          ans_buf_addr <= buf_reg;
          ans_code <= rdata[CTL_RESP] ? ANS_REPLY : ANS_SC;
          addr_reg <= entry_reg;
          st_reg <= rdata[CTL_RESP] ? S_RSENT : S_IDLE;
        end
        S_RSENT:
        begin
          hif.reply_irq <= 1'b1;
          st_reg <= S_IDLE;
        end
        default:
          st_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// File: hw/dpx_host.sv
// Purpose: host end: APB registers driving mode, RAM and interrupts
// Assumes: APB master with 32-bit data, one wait state per access
// Notes: software runs the buffer handshake through the RAM window
`timescale 1ns/1ns
module dpx_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Engine side
  dpx_if.host hif,
  // Interrupt summary
  output logic irq
);
  import dpx_pkg::*;

  logic [3:0] irq_reg;
  logic [3:0] irq_set;
  logic [6:0] mode_reg;
  logic [10:0] ram_addr_reg;
  logic [4:0] links_reg;
  logic done;
  logic wr;
  logic mapped;

  assign done = psel && penable && pready;
  assign wr = done && pwrite;
  assign mapped = paddr == REG_MODE || paddr == REG_RAM_ADDR ||
    paddr == REG_RAM_DATA || paddr == REG_IRQ ||
    paddr == REG_STATUS || paddr == REG_LINKS;
  assign irq_set = {hif.reply_irq, hif.request_irq, hif.ext_prm_irq,
    hif.prm_irq};
  assign hif.mode0 = mode_reg;
  assign hif.ram_addr = ram_addr_reg;
  assign hif.link_count = links_reg;

  // ----------------------------------------------------------------
  // APB handshake, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite)
        case (paddr)
          REG_MODE: prdata <= {25'h0, mode_reg};
          REG_RAM_ADDR: prdata <= {21'h0, ram_addr_reg};
          REG_RAM_DATA: prdata <= {24'h0, hif.ram_rdata};
          REG_IRQ: prdata <= {28'h0, irq_reg};
          REG_STATUS: prdata <= {28'h0, hif.link_overflow,
            hif.prm_fault, hif.dp_state};
          REG_LINKS: prdata <= {27'h0, links_reg};
          default: prdata <= 32'h0000_0000;
        endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode register 0 and link count
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= MODE_RESET;
      links_reg <= 5'h00;
    end
    else if (wr && paddr == REG_MODE)
    begin
      mode_reg <= pwdata[6:0];
      // special buffer mode blocked with SAP 53
      if (pwdata[MODE_EXT_PRM])
        mode_reg[MODE_SPEC_PRM] <= 1'b0;
    end
    // links only with watchdog; count stored uncapped, above 29 flagged as overflow
    else if (wr && paddr == REG_LINKS)
      links_reg <= mode_reg[MODE_WD_EN] ? pwdata[4:0] : 5'h00;
  end

  // ----------------------------------------------------------------
  // RAM window
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ram_addr_reg <= 11'h000;
      hif.ram_we <= 1'b0;
      hif.ram_wdata <= 8'h00;
    end
    else
    begin
      hif.ram_we <= 1'b0;
      if (wr && paddr == REG_RAM_ADDR)
        ram_addr_reg <= pwdata[10:0];
      // list and pointer built through this window
      if (wr && paddr == REG_RAM_DATA)
      begin
        hif.ram_we <= 1'b1;
        hif.ram_wdata <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky interrupts, write one to clear, set wins
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_reg <= 4'h0;
      irq <= 1'b0;
    end
    else
    begin
      // host clears any of the prm, ext prm, request and reply interrupts
      if (wr && paddr == REG_IRQ)
        irq_reg <= (irq_reg & ~pwdata[3:0]) | irq_set;
      else
        irq_reg <= irq_reg | irq_set;
      irq <= |(irq_reg | irq_set);
    end
  end
endmodule

// File: pkg/dpx_if.sv
// Purpose: link between the engine and the host end
// Assumes: one clock, shared RAM inside the engine
// Notes: interrupt lines are one-cycle pulses
`timescale 1ns/1ns
interface dpx_if;
  logic ram_we;
  logic [10:0] ram_addr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic [6:0] mode0;
  logic [4:0] link_count;
  logic prm_irq;
  logic ext_prm_irq;
  logic request_irq;
  logic reply_irq;
  logic prm_fault;
  logic link_overflow;
  logic [1:0] dp_state;
  modport engine (input ram_we, ram_addr, ram_wdata, mode0, link_count,
    output ram_rdata, prm_irq, ext_prm_irq, request_irq, reply_irq,
    prm_fault, link_overflow, dp_state);
  modport host (output ram_we, ram_addr, ram_wdata, mode0, link_count,
    input ram_rdata, prm_irq, ext_prm_irq, request_irq, reply_irq,
    prm_fault, link_overflow, dp_state);
endinterface

// File: pkg/dpx_pkg.sv
// Purpose: shared constants and types for the acyclic/extension engine
// Assumes: shared RAM of byte cells, segments of eight bytes
// Notes: used by the engine, the host end and the bench
package dpx_pkg;
  // ----------------------------------------------------------------
  // Shared RAM layout
  // ----------------------------------------------------------------
  localparam int RAM_AW = 11;
  localparam logic [10:0] SAP_LIST_PTR_ADDR = 11'h017;
  localparam int SEG_SHIFT = 3;
  localparam logic [7:0] LIST_END = 8'hFF;
  localparam logic [10:0] ENTRY_SIZE = 11'h007;
  localparam logic [10:0] OFS_SRC_STATION = 11'h001;
  localparam logic [10:0] OFS_SRC_SAP = 11'h002;
  localparam logic [10:0] OFS_SERVICE = 11'h003;
  localparam logic [10:0] OFS_REQ_PTR0 = 11'h004;
  localparam logic [10:0] OFS_REQ_PTR1 = 11'h005;
  localparam logic [10:0] OFS_REPLY_PTR = 11'h006;
  localparam logic [10:0] OFS_BUF_LEN = 11'h002;
  localparam logic [10:0] OFS_BUF_FC = 11'h003;
  localparam int REPLY_DONE_BIT = 7;
  localparam logic [7:0] SERVICE_ANY = 8'h00;
  // Buffer control byte
  localparam int CTL_HOST = 7;
  localparam int CTL_PEND = 6;
  localparam int CTL_RESP = 5;
  localparam int CTL_ENG = 4;
  // ----------------------------------------------------------------
  // Parameter telegram fields
  // ----------------------------------------------------------------
  localparam int ST1_ACYC = 7;
  localparam int ST1_FAILSAFE = 6;
  localparam int ST1_PUBLISH = 5;
  localparam int ST3_PRMCMD = 7;
  localparam int ST3_STRUCT = 3;
  localparam logic [7:0] BLK_HDR_LEN = 8'h04;
  localparam logic [7:0] BLK_MAX_LEN = 8'hF4;
  localparam logic [7:0] LINK_TYPE_A = 8'h03;
  localparam logic [7:0] LINK_TYPE_B = 8'h07;
  localparam logic [7:0] LINK_VERSION = 8'h01;
  localparam logic [7:0] LINK_MAX_LEN = 8'h79;
  localparam logic [7:0] FC_PUBLISH = 8'h07;
  localparam logic [7:0] DEST_BROADCAST = 8'h7F;
  localparam logic [4:0] MAX_LINKS = 5'h1D;
  // ----------------------------------------------------------------
  // APB register map of the host end
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_RAM_ADDR = 8'h04;
  localparam logic [7:0] REG_RAM_DATA = 8'h08;
  localparam logic [7:0] REG_IRQ = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_LINKS = 8'h14;
  localparam int MODE_ONLINE = 0;
  localparam int MODE_EXT_PRM = 1;
  localparam int MODE_REDUND = 2;
  localparam int MODE_FAILSAFE = 3;
  localparam int MODE_SPEC_PRM = 4;
  localparam int MODE_EXT_USE = 5;
  localparam int MODE_WD_EN = 6;
  localparam logic [6:0] MODE_RESET = 7'h00;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TG_PRM, TG_EXT_PRM, TG_CHK_CFG, TG_DX, TG_ACYC_REQ, TG_ACYC_POLL
  } dpx_tg_t;
  typedef enum logic [2:0] {
    ANS_SC, ANS_RS, ANS_RR, ANS_REPLY, ANS_DATA, ANS_PUBLISH
  } dpx_ans_t;
  typedef enum logic [1:0] {
    DP_OFFLINE, DP_WAIT_PRM, DP_WAIT_CFG, DP_DATA_EX
  } dpx_dp_t;
endpackage

// File: verif/dp_extension_acyclic_sap_engine_bench.sv
// Purpose: self-checking bench of engine and host end
// Assumes: APB master tasks, one telegram at a time
// Notes: block type, slot, reserved and version are held fixed; length varies
`timescale 1ns/1ns
module dp_extension_acyclic_sap_engine_bench;
  import dpx_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00, tg_sap = 8'h00, tg_st = 8'h00;
  logic [7:0] tg_ss = 8'h00, tg_s1 = 8'h00, ans_dest;
  logic [7:0] tg_svc = 8'h05, tg_fc = 8'h00, tg_len = 8'h09;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, tg_valid = 0, tg_ready, ans_valid;
  logic [10:0] ans_buf_addr;
  dpx_tg_t tg_kind = TG_PRM;
  dpx_ans_t ans_code;
  int n_fail = 0, tests_run = 0;
  logic [10:0] ia [12] = '{11'h017, 11'h020, 11'h021, 11'h022, 11'h023,
    11'h024, 11'h025, 11'h026, 11'h027, 11'h040, 11'h050, 11'h060};
  logic [7:0] id [12] = '{8'h04, 8'h05, 8'h02, 8'h30, 8'h00, 8'h08,
    8'h0A, 8'h0C, 8'hFF, 8'h00, 8'h00, 8'h00};
  dpx_if link_i();
  dpx_host dpx_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hif(link_i),
    .irq(irq));
  dpx_engine dpx_engine_i (.pclk(pclk), .presetn(presetn), .hif(link_i),
    .tg_valid(tg_valid), .tg_kind(tg_kind), .tg_sap(tg_sap),
    .tg_src_station(tg_st), .tg_src_sap(tg_ss), .tg_service(tg_svc),
    .tg_fc(tg_fc), .tg_len(tg_len), .tg_status1(tg_s1),
    .tg_status3(8'h08),
    .tg_blk_type(8'h03), .tg_blk_slot(8'h00),
    .tg_blk_rsvd(8'h00), .tg_blk_ver(8'h01), .tg_ready(tg_ready),
    .ans_valid(ans_valid), .ans_code(ans_code), .ans_dest(ans_dest),
    .ans_buf_addr(ans_buf_addr));
  dpx_monitor dpx_monitor_i (.pclk(pclk), .presetn(presetn),
    .mode0(link_i.mode0), .link_count(link_i.link_count),
    .prm_irq(link_i.prm_irq), .ext_prm_irq(link_i.ext_prm_irq),
    .request_irq(link_i.request_irq), .reply_irq(link_i.reply_irq),
    .link_overflow(link_i.link_overflow), .dp_state(link_i.dp_state));
  // ----------
  // Tasks
  // ----------
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task ram(input logic w, input logic [10:0] a, input logic [7:0] d);
    apb(1'b1, REG_RAM_ADDR, {21'h0, a});
    apb(w, REG_RAM_DATA, {24'h0, d});
  endtask
  task tg(input dpx_tg_t k, input logic [7:0] st, ss, s1);
    tg_kind <= k;
    tg_sap <= 8'h05;
    tg_st <= st;
    tg_ss <= ss;
    tg_s1 <= s1;
    tg_valid <= 1'b1;
    @(posedge pclk);
    while (tg_ready !== 1'b1)
      @(posedge pclk);
    tg_valid <= 1'b0;
    @(posedge pclk);
    while (ans_valid !== 1'b1)
      @(posedge pclk);
    @(posedge pclk);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
    forever #4 pclk = ~pclk;
  initial
  begin
    #400000;
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 12; i++)
      ram(1'b1, ia[i], id[i]);
    apb(1'b1, REG_MODE, 32'h7B);
    apb(1'b0, REG_MODE, 32'h0);
    chk("mode", 32'h6B, rd);
    apb(1'b1, REG_LINKS, 32'h1E);
    apb(1'b0, 8'h18, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("setup done");
    tg(TG_PRM, 8'h00, 8'h00, 8'h00);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("fault", 32'h4, rd & 32'h4);
    tg(TG_ACYC_REQ, 8'h02, 8'h30, 8'h00);
    chk("acyc off", ANS_RS, ans_code);
    tg(TG_PRM, 8'h00, 8'h00, 8'hC0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h0A, rd);
    tg(TG_EXT_PRM, 8'h00, 8'h00, 8'h00);
    apb(1'b0, REG_IRQ, 32'h0);
    chk("prm irq", 32'h3, rd);
    apb(1'b1, REG_IRQ, 32'hF);
    tg(TG_CHK_CFG, 8'h00, 8'h00, 8'h00);
    tg(TG_EXT_PRM, 8'h00, 8'h00, 8'h00);
    chk("late ext", ANS_RS, ans_code);
    $display("parameter test done");
    tg(TG_ACYC_REQ, 8'h03, 8'h30, 8'h00);
    chk("station", ANS_RS, ans_code);
    tg(TG_ACYC_REQ, 8'h02, 8'h31, 8'h00);
    chk("source sap", ANS_RS, ans_code);
    tg(TG_ACYC_REQ, 8'h02, 8'h30, 8'h00);
    chk("buf0", 32'h40, {21'h0, ans_buf_addr});
    chk("dest", 32'h02, {24'h0, ans_dest});
    ram(1'b0, 11'h040, 8'h00);
    chk("ctrl0", 32'hC0, rd);
    ram(1'b0, 11'h042, 8'h00);
    chk("len0", 32'h09, rd);
    tg(TG_ACYC_REQ, 8'h02, 8'h30, 8'h00);
    chk("buf1", 32'h50, {21'h0, ans_buf_addr});
    tg(TG_ACYC_REQ, 8'h02, 8'h30, 8'h00);
    chk("no buf", ANS_RR, ans_code);
    chk("irq pin", 32'h1, {31'h0, irq});
    apb(1'b1, REG_IRQ, 32'hF);
    $display("request test done");
    tg(TG_ACYC_POLL, 8'h02, 8'h30, 8'h00);
    chk("poll", ANS_SC, ans_code);
    ram(1'b1, 11'h060, 8'hA0);
    tg(TG_ACYC_POLL, 8'h02, 8'h30, 8'h00);
    chk("reply", 32'h60, {21'h0, ans_buf_addr});
    ram(1'b0, 11'h060, 8'h00);
    chk("reply ctrl", 32'h0, rd);
    ram(1'b0, 11'h020, 8'h00);
    chk("done flag", 32'h85, rd);
    apb(1'b0, REG_IRQ, 32'h0);
    chk("reply irq", 32'h8, rd);
    $display("reply test done");
    tg_len <= 8'h03;
    tg(TG_PRM, 8'h00, 8'h00, 8'hE0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("short blk", 32'h4, rd & 32'h4);
    tg_fc <= 8'h07;
    tg(TG_DX, 8'h09, 8'h00, 8'h00);
    chk("publish", ANS_PUBLISH, ans_code);
    chk("bcast dest", 32'h7F, {24'h0, ans_dest});
    $display("publish test done");
    report_and_stop();
  end
endmodule

// File: verif/dpx_monitor.sv
// Purpose: assertions on the engine-host link
// Assumes: one clock, reset active low
// Notes: takes link signals as plain inputs
`timescale 1ns/1ns
module dpx_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic [6:0] mode0,
  input wire logic [4:0] link_count,
  input wire logic prm_irq,
  input wire logic ext_prm_irq,
  input wire logic request_irq,
  input wire logic reply_irq,
  input wire logic link_overflow,
  input wire logic [1:0] dp_state
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------
  // Checks
  // ----------
  link_ovf_a:
    assert property (1'h1 |=> link_overflow == ($past(link_count) > 5'h1D))
    else $error("overflow flag wrong");
  ext_state_a:
    assert property (ext_prm_irq |-> dp_state == 2'h2)
    else $error("ext prm outside wait cfg");
  ext_mode_a:
    assert property (ext_prm_irq |-> mode0[1])
    else $error("ext prm while disabled");
  irq_apart_a:
    assert property (ext_prm_irq |-> !prm_irq)
    else $error("prm kinds not told apart");
  req_pulse_a:
    assert property (request_irq |=> !request_irq [*3])
    else $error("request pulse too long");
  reply_pulse_a:
    assert property ($rose(reply_irq) |=> $fell(reply_irq))
    else $error("reply pulse too long");
  offline_hold_a:
    assert property (dp_state == 2'h0 && !mode0[0] |=> dp_state == 2'h0)
    else $error("left offline");
  acyc_state_a:
    assert property (request_irq || reply_irq |-> dp_state != 2'h0)
    else $error("acyclic event offline");
endmodule
